// file: pkg/ocs_defines.vh
`ifndef OCS_DEFINES_VH
`define OCS_DEFINES_VH

// register byte offsets on the bus
`define OCS_REG_CTRL        8'h00
`define OCS_REG_CMD         8'h04
`define OCS_REG_CHLIST      8'h08
`define OCS_REG_DIV         8'h0C
`define OCS_REG_SINGLE      8'h10
`define OCS_REG_DATA        8'h14
`define OCS_REG_STATUS      8'h18
`define OCS_REG_LEVEL       8'h1C
`define OCS_REG_THRESH      8'h20

// control register fields
`define OCS_CTRL_TRIG_EXT   0
`define OCS_CTRL_TRIG_FALL  1
`define OCS_CTRL_CLK_EXT    2
`define OCS_CTRL_WRAP       3
`define OCS_CTRL_W          4

// command register fields (write-one pulses)
`define OCS_CMD_START       0
`define OCS_CMD_STOP        1
`define OCS_CMD_CLR_ERR     2
`define OCS_CMD_FLUSH       3

// single-value register fields
`define OCS_SGL_VAL_MSB     15
`define OCS_SGL_CH_LSB      16
`define OCS_SGL_CH_MSB      18

// status register fields
`define OCS_ST_RUN          0
`define OCS_ST_ARMED        1
`define OCS_ST_UNDER        2
`define OCS_ST_OVER         3
`define OCS_ST_BUSY         4

// channel codes
`define OCS_NUM_AO          4
`define OCS_NUM_CH          5
`define OCS_CH_DIG          3'h4

// reset values
`define OCS_CTRL_RST        4'h0
`define OCS_CHLIST_RST      5'h01
`define OCS_DIV_RST         32'h0000_00C8
`define OCS_THRESH_RST      8'h00
`define OCS_DIG_RST         16'h0000

// build choices and storage
`define OCS_DAC_BITS_DEF    16
`define OCS_STORE_DEPTH     131072
`define OCS_STORE_ONE       131072
`define OCS_STORE_PER_CH    24576
`define OCS_STORE_MULTI     (`OCS_NUM_CH * `OCS_STORE_PER_CH)

// pacing timing
`define OCS_CLK_HZ          100000000
`define OCS_MAX_RATE_SPS    500000
`define OCS_MIN_RATE_MSPS   750
`define OCS_PACE_MIN_DIV    (`OCS_CLK_HZ / `OCS_MAX_RATE_SPS)
`define OCS_PACE_MAX_DIV    ((64'd1000 * `OCS_CLK_HZ) / `OCS_MIN_RATE_MSPS)

`endif

// file: logic/ocs_pacer.v
`timescale 1ns/1ns
`include "ocs_defines.vh"

module ocs_pacer #(
  parameter [31:0] MIN_DIV = `OCS_PACE_MIN_DIV,
  parameter [31:0] MAX_DIV = 32'h07F2_8155
) (
  input  wire        i_ref_clk,
  input  wire        i_sys_rst,
  input  wire        i_run,
  input  wire [31:0] i_div,
  output reg         o_tick
);

reg  [31:0] cnt_r;
wire [31:0] div_lim;

// out-of-range divisors are clamped rather than refused
assign div_lim = (i_div < MIN_DIV) ? MIN_DIV : ((i_div > MAX_DIV) ? MAX_DIV : i_div);

always @(posedge i_ref_clk or posedge i_sys_rst) begin
  if (i_sys_rst) begin
    cnt_r  <= 32'h0000_0000;
    o_tick <= 1'b0;
  end else if (!i_run) begin
    cnt_r  <= 32'h0000_0000;
    o_tick <= 1'b0;
  end else if (cnt_r >= div_lim - 32'h0000_0001) begin
    cnt_r  <= 32'h0000_0000;
    o_tick <= 1'b1;
  end else begin
    cnt_r  <= cnt_r + 32'h0000_0001;
    o_tick <= 1'b0;
  end
end

endmodule // ocs_pacer

// file: logic/ocs_sequencer.v
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "ocs_defines.vh"

// What this block does
// - converter width fixed by build, 12/16
// - codes 0-3 analog, code 4 digital port
// - up to five ascending entries, omitted untouched
// - storage 128K one channel, 24K each five
// - each channel up to 500 kS/s
// - digital port sequenced like analog channels
// - threshold output takes 8-bit raw count
// - software trigger starts on start command
// - external trigger on chosen edge starts
// - internal pacing 0.75 S/s to 500 kS/s
// - external pacing on rising input edges
// - single value writes immediately, unpaced, unstoppable
// - continuous: list, pacing, trigger, buffer, wrap
// - waveform channels share count, clock, trigger
// - listed outputs update together per pace
// - pace with no data: underflow, hold
// - pace while loading: over-sample error
module ocs_sequencer #(
  parameter        DAC_BITS     = `OCS_DAC_BITS_DEF,
  parameter        DEPTH        = `OCS_STORE_DEPTH,
  parameter [63:0] PACE_MAX_DIV = `OCS_PACE_MAX_DIV
) (
  input  wire                i_ref_clk,
  input  wire                i_sys_rst,
  input  wire                i_hsel,
  input  wire [31:0]         i_haddr,
  input  wire [1:0]          i_htrans,
  input  wire                i_hwrite,
  input  wire [2:0]          i_hsize,
  input  wire [31:0]         i_hwdata,
  input  wire                i_hready,
  output wire [31:0]         o_hrdata,
  output wire                o_hreadyout,
  output wire                o_hresp,
  input  wire                i_ext_trig,
  input  wire                i_ext_clk,
  output wire [DAC_BITS-1:0] o_analog_out_0,
  output wire [DAC_BITS-1:0] o_analog_out_1,
  output wire [DAC_BITS-1:0] o_analog_out_2,
  output wire [DAC_BITS-1:0] o_analog_out_3,
  output wire [15:0]         o_dig_out,
  output wire [7:0]          o_thresh_level,
  output wire                o_update
);

localparam AW = $clog2(DEPTH);
localparam [2:0] S_IDLE  = 3'h0;
localparam [2:0] S_ARM   = 3'h1;
localparam [2:0] S_RUN   = 3'h2;
localparam [2:0] S_LOAD  = 3'h3;
localparam [2:0] S_APPLY = 3'h4;
localparam [DAC_BITS-1:0] AO_MID = {1'b1, {(DAC_BITS-1){1'b0}}};
// caps are clipped to the store, so a small build still accepts samples
localparam integer CAP_ONE   = (`OCS_STORE_ONE < DEPTH) ? `OCS_STORE_ONE : DEPTH;
localparam integer CAP_MULTI = (`OCS_STORE_MULTI < DEPTH) ? `OCS_STORE_MULTI : DEPTH;
localparam [AW:0] LIM_ONE   = CAP_ONE[AW:0];
localparam [AW:0] LIM_MULTI = CAP_MULTI[AW:0];
localparam [AW:0] DEPTH_W   = DEPTH;

////////////////////////////////////////////////////////////////////////////////
// bus slave: zero wait states, always OKAY

reg  [31:0]             hrdata_r;
reg                     wr_pend_r;
reg  [7:0]              addr_r;
reg  [31:0]             rd_mux;
wire                    addr_ph;

assign addr_ph     = i_hsel & i_htrans[1] & i_hready;
assign o_hrdata    = hrdata_r;
assign o_hreadyout = 1'b1;
assign o_hresp     = 1'b0;

wire wr_ctrl   = wr_pend_r & (addr_r == `OCS_REG_CTRL);
wire wr_cmd    = wr_pend_r & (addr_r == `OCS_REG_CMD);
wire wr_chlist = wr_pend_r & (addr_r == `OCS_REG_CHLIST);
wire wr_div    = wr_pend_r & (addr_r == `OCS_REG_DIV);
wire wr_single = wr_pend_r & (addr_r == `OCS_REG_SINGLE);
wire wr_data   = wr_pend_r & (addr_r == `OCS_REG_DATA);
wire wr_thresh = wr_pend_r & (addr_r == `OCS_REG_THRESH);

wire cmd_start   = wr_cmd & i_hwdata[`OCS_CMD_START];
wire cmd_stop    = wr_cmd & i_hwdata[`OCS_CMD_STOP];
wire cmd_clr_err = wr_cmd & i_hwdata[`OCS_CMD_CLR_ERR];
wire cmd_flush   = wr_cmd & i_hwdata[`OCS_CMD_FLUSH];

////////////////////////////////////////////////////////////////////////////////
// software-visible settings

reg  [`OCS_CTRL_W-1:0]  ctrl_r;
reg  [`OCS_NUM_CH-1:0]  chlist_r;
reg  [31:0]             div_r;
reg  [7:0]              thresh_r;
reg  [2:0]              state_r;
reg  [2:0]              state_nxt;
reg                     under_r;
reg                     over_r;

wire trig_ext  = ctrl_r[`OCS_CTRL_TRIG_EXT];
wire trig_fall = ctrl_r[`OCS_CTRL_TRIG_FALL];
wire clk_ext   = ctrl_r[`OCS_CTRL_CLK_EXT];
wire wrap_mode = ctrl_r[`OCS_CTRL_WRAP];
wire idle      = (state_r == S_IDLE);

always @(posedge i_ref_clk or posedge i_sys_rst) begin
  if (i_sys_rst) begin
    wr_pend_r <= 1'b0;
    addr_r    <= 8'h00;
    hrdata_r  <= 32'h0000_0000;
    ctrl_r    <= `OCS_CTRL_RST;
    chlist_r  <= `OCS_CHLIST_RST;
    div_r     <= `OCS_DIV_RST;
    thresh_r  <= `OCS_THRESH_RST;
  end else begin
    wr_pend_r <= addr_ph & i_hwrite;
    if (addr_ph) begin
      addr_r <= i_haddr[7:0];
    end
    if (addr_ph & ~i_hwrite) begin
      hrdata_r <= rd_mux;
    end
    // mode, list and pacing are frozen while an operation is active
    if (wr_ctrl & idle) begin
      ctrl_r <= i_hwdata[`OCS_CTRL_W-1:0];
    end
    if (wr_chlist & idle) begin
      chlist_r <= i_hwdata[`OCS_NUM_CH-1:0];
    end
    if (wr_div & idle) begin
      div_r <= i_hwdata;
    end
    if (wr_thresh) begin
      thresh_r <= i_hwdata[7:0];
    end
  end
end

assign o_thresh_level = thresh_r;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge detection

reg trig_s1_r;
reg trig_s2_r;
reg trig_s3_r;
reg clk_s1_r;
reg clk_s2_r;
reg clk_s3_r;

always @(posedge i_ref_clk or posedge i_sys_rst) begin
  if (i_sys_rst) begin
    trig_s1_r <= 1'b0;
    trig_s2_r <= 1'b0;
    trig_s3_r <= 1'b0;
    clk_s1_r  <= 1'b0;
    clk_s2_r  <= 1'b0;
    clk_s3_r  <= 1'b0;
  end else begin
    trig_s1_r <= i_ext_trig;
    trig_s2_r <= trig_s1_r;
    trig_s3_r <= trig_s2_r;
    clk_s1_r  <= i_ext_clk;
    clk_s2_r  <= clk_s1_r;
    clk_s3_r  <= clk_s2_r;
  end
end

wire trig_edge = trig_fall ? (~trig_s2_r & trig_s3_r) : (trig_s2_r & ~trig_s3_r);
wire ext_pace  = clk_s2_r & ~clk_s3_r;
wire int_pace;
wire paced_st  = (state_r == S_RUN) | (state_r == S_LOAD) | (state_r == S_APPLY);
// one pacing source drives every listed channel
wire pace_evt  = paced_st & (clk_ext ? ext_pace : int_pace);

ocs_pacer #(
  .MIN_DIV (`OCS_PACE_MIN_DIV),
  .MAX_DIV (PACE_MAX_DIV[31:0])
) u_pacer (
  .i_ref_clk (i_ref_clk),
  .i_sys_rst (i_sys_rst),
  .i_run     (paced_st & ~clk_ext),
  .i_div     (div_r),
  .o_tick    (int_pace)
);

////////////////////////////////////////////////////////////////////////////////
// sample store

reg  [15:0]             mem_r [0:DEPTH-1];
reg  [AW-1:0]           wr_ptr_r;
reg  [AW-1:0]           rd_ptr_r;
reg  [AW:0]             level_r;
reg  [2:0]              ch_r;
reg  [2:0]              n_ch;
reg  [AW:0]             limit;
integer                 k;

always @* begin
  n_ch = 3'h0;
  for (k = 0; k < `OCS_NUM_CH; k = k + 1) begin
    n_ch = n_ch + {2'b00, chlist_r[k]};
  end
  // capacity per channel shrinks as more channels are listed
  limit = (n_ch == 3'h1) ? LIM_ONE : LIM_MULTI;
end

wire          wr_acc  = wr_data & (level_r < limit) & (level_r < DEPTH_W);
wire          take    = (state_r == S_LOAD) & chlist_r[ch_r];
wire          consume = take & ~wrap_mode;
wire [AW:0]   rd_inc  = {1'b0, rd_ptr_r} + {{AW{1'b0}}, 1'b1};
wire          avail   = (n_ch != 3'h0) & (level_r >= {{(AW-2){1'b0}}, n_ch});
wire [15:0]   rd_word = mem_r[rd_ptr_r];

always @(posedge i_ref_clk) begin
  if (wr_acc) begin
    mem_r[wr_ptr_r] <= i_hwdata[15:0];
  end
end

always @(posedge i_ref_clk or posedge i_sys_rst) begin
  if (i_sys_rst) begin
    wr_ptr_r <= {AW{1'b0}};
    rd_ptr_r <= {AW{1'b0}};
    level_r  <= {(AW+1){1'b0}};
  end else if (cmd_flush & idle) begin
    wr_ptr_r <= {AW{1'b0}};
    rd_ptr_r <= {AW{1'b0}};
    level_r  <= {(AW+1){1'b0}};
  end else begin
    if (wr_acc) begin
      wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
    end
    if (take) begin
      if (wrap_mode & (rd_inc == level_r)) begin
        rd_ptr_r <= {AW{1'b0}};
      end else begin
        rd_ptr_r <= rd_inc[AW-1:0];
      end
    end
    // waveform mode keeps the pattern, so only paced mode drains it
    if (wr_acc & ~consume) begin
      level_r <= level_r + {{AW{1'b0}}, 1'b1};
    end else if (consume & ~wr_acc) begin
      level_r <= level_r - {{AW{1'b0}}, 1'b1};
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer

always @* begin
  state_nxt = state_r;
  case (state_r)
    S_IDLE: begin
      if (cmd_start) begin
        state_nxt = trig_ext ? S_ARM : S_RUN;
      end
    end
    S_ARM: begin
      if (trig_edge) begin
        state_nxt = S_RUN;
      end
    end
    S_RUN: begin
      if (pace_evt & avail) begin
        state_nxt = S_LOAD;
      end
    end
    S_LOAD: begin
      // walks all five codes: 5 cycles, far below the 200-cycle pace period
      if (ch_r == `OCS_CH_DIG) begin
        state_nxt = S_APPLY;
      end
    end
    S_APPLY: begin
      state_nxt = S_RUN;
    end
    default: begin
      state_nxt = S_IDLE;
    end
  endcase
  if (cmd_stop) begin
    state_nxt = S_IDLE;
  end
end

reg [15:0] stage_r [0:`OCS_NUM_CH-1];
reg        update_r;

always @(posedge i_ref_clk or posedge i_sys_rst) begin
  if (i_sys_rst) begin
    state_r  <= S_IDLE;
    ch_r     <= 3'h0;
    update_r <= 1'b0;
    under_r  <= 1'b0;
    over_r   <= 1'b0;
  end else begin
    state_r  <= state_nxt;
    update_r <= (state_r == S_APPLY) & ~cmd_stop;
    if (state_r == S_LOAD) begin
      ch_r <= ch_r + 3'h1;
    end else begin
      ch_r <= 3'h0;
    end
    // a new event in the clearing cycle wins over the clear
    if ((state_r == S_RUN) & pace_evt & ~avail & (n_ch != 3'h0)) begin
      under_r <= 1'b1;
    end else if (cmd_clr_err) begin
      under_r <= 1'b0;
    end
    if (pace_evt & ((state_r == S_LOAD) | (state_r == S_APPLY))) begin
      over_r <= 1'b1;
    end else if (cmd_clr_err) begin
      over_r <= 1'b0;
    end
  end
end

always @(posedge i_ref_clk) begin
  if (take) begin
    stage_r[ch_r] <= rd_word;
  end
end

assign o_update = update_r;

////////////////////////////////////////////////////////////////////////////////
// output registers

wire                       sgl_wr  = wr_single;
wire [2:0]                 sgl_ch  = i_hwdata[`OCS_SGL_CH_MSB:`OCS_SGL_CH_LSB];
wire [15:0]                sgl_val = i_hwdata[`OCS_SGL_VAL_MSB:0];
wire                       apply   = (state_r == S_APPLY) & ~cmd_stop;
wire [4*DAC_BITS-1:0]      ao_bus;
reg  [15:0]                dig_r;

genvar g;
generate
  for (g = 0; g < `OCS_NUM_AO; g = g + 1) begin : g_ao
    reg [DAC_BITS-1:0] val_r;
    always @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
        val_r <= AO_MID; // midscale is 0 V in offset binary
      end else if (sgl_wr & (sgl_ch == g)) begin
        val_r <= sgl_val[DAC_BITS-1:0];
      end else if (apply & chlist_r[g]) begin
        val_r <= stage_r[g][DAC_BITS-1:0];
      end
    end
    assign ao_bus[g*DAC_BITS +: DAC_BITS] = val_r;
  end
endgenerate

always @(posedge i_ref_clk or posedge i_sys_rst) begin
  if (i_sys_rst) begin
    dig_r <= `OCS_DIG_RST;
  end else if (sgl_wr & (sgl_ch == `OCS_CH_DIG)) begin
    dig_r <= sgl_val;
  end else if (apply & chlist_r[`OCS_CH_DIG]) begin
    dig_r <= stage_r[`OCS_CH_DIG];
  end
end

assign o_analog_out_0 = ao_bus[0*DAC_BITS +: DAC_BITS];
assign o_analog_out_1 = ao_bus[1*DAC_BITS +: DAC_BITS];
assign o_analog_out_2 = ao_bus[2*DAC_BITS +: DAC_BITS];
assign o_analog_out_3 = ao_bus[3*DAC_BITS +: DAC_BITS];
assign o_dig_out      = dig_r;

////////////////////////////////////////////////////////////////////////////////
// read mux, sampled in the address phase

always @* begin
  rd_mux = 32'h0000_0000;
  case (i_haddr[7:0])
    `OCS_REG_CTRL: begin
      rd_mux[`OCS_CTRL_W-1:0] = ctrl_r;
    end
    `OCS_REG_CHLIST: begin
      rd_mux[`OCS_NUM_CH-1:0] = chlist_r;
    end
    `OCS_REG_DIV: begin
      rd_mux = div_r;
    end
    `OCS_REG_STATUS: begin
      rd_mux[`OCS_ST_RUN]   = ~idle;
      rd_mux[`OCS_ST_ARMED] = (state_r == S_ARM);
      rd_mux[`OCS_ST_UNDER] = under_r;
      rd_mux[`OCS_ST_OVER]  = over_r;
      rd_mux[`OCS_ST_BUSY]  = (state_r == S_LOAD) | (state_r == S_APPLY);
    end
    `OCS_REG_LEVEL: begin
      rd_mux[AW:0] = level_r;
    end
    `OCS_REG_THRESH: begin
      rd_mux[7:0] = thresh_r;
    end
    default: begin
      rd_mux = 32'h0000_0000;
    end
  endcase
end

endmodule // ocs_sequencer

// file: verification/ocs_chk.sv
`timescale 1ns/1ns
`include "ocs_defines.vh"

module ocs_chk #(
  parameter DAC_BITS = 16
) (
  input wire                i_ref_clk,
  input wire                i_sys_rst,
  input wire                i_hsel,
  input wire [31:0]         i_haddr,
  input wire [1:0]          i_htrans,
  input wire                i_hwrite,
  input wire [31:0]         i_hwdata,
  input wire                i_hready,
  input wire [31:0]         o_hrdata,
  input wire                o_hreadyout,
  input wire                o_hresp,
  input wire [DAC_BITS-1:0] o_analog_out_0,
  input wire [15:0]         o_dig_out,
  input wire [7:0]          o_thresh_level,
  input wire                o_update
);
  wire       req = i_hsel & i_htrans[1] & i_hready;
  wire [7:0] adr = i_haddr[7:0];
  reg        sgl_r;
  reg        thr_r;
  reg        unm_r;

  // data-phase markers, one cycle after the address phase was taken
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sgl_r <= 1'b0;
      thr_r <= 1'b0;
      unm_r <= 1'b0;
    end else begin
      sgl_r <= req & i_hwrite & (adr == `OCS_REG_SINGLE);
      thr_r <= req & i_hwrite & (adr == `OCS_REG_THRESH);
      unm_r <= req & !i_hwrite & (adr > `OCS_REG_THRESH);
    end
  end

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////////////////////////////////////////
  a_bus_ready: assert property (o_hreadyout)
    else $error("bus wait state seen");
  a_bus_okay: assert property (!o_hresp)
    else $error("bus error response seen");
  a_unmapped_zero: assert property (unm_r |-> o_hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_update_pulse: assert property (o_update |=> !o_update)
    else $error("update pulse too long");
  // a paced change of analog output 0 always comes with the update pulse
  a_outs_together: assert property ($changed(o_analog_out_0) && !$past(sgl_r)
    |-> ##[0:1] o_update)
    else $error("output changed without update");
  a_single_ch0: assert property (sgl_r && i_hwdata[18:16] == 3'h0
    |=> o_analog_out_0 == $past(i_hwdata[DAC_BITS-1:0]))
    else $error("single write to converter 0 lost");
  a_single_dig: assert property (sgl_r && i_hwdata[18:16] == `OCS_CH_DIG
    |=> o_dig_out == $past(i_hwdata[15:0]))
    else $error("single write to digital port lost");
  a_thresh_write: assert property (thr_r |=> o_thresh_level == $past(i_hwdata[7:0]))
    else $error("threshold count not taken");
  a_thresh_cause: assert property ($changed(o_thresh_level) |-> $past(thr_r))
    else $error("threshold changed without write");
endmodule // ocs_chk

bind ocs_sequencer ocs_chk #(.DAC_BITS(DAC_BITS)) u_chk (.*);

// file: verification/ocs_host.sv
`timescale 1ns/1ns
`include "ocs_defines.vh"

module ocs_host (
  input  wire        i_ref_clk,
  input  wire [31:0] i_hrdata,
  input  wire        i_hready,
  output reg         o_hsel   = 1'b0,
  output reg  [31:0] o_haddr  = 32'h0000_0000,
  output reg  [1:0]  o_htrans = 2'b00,
  output reg         o_hwrite = 1'b0,
  output reg  [2:0]  o_hsize  = 3'h2,
  output reg  [31:0] o_hwdata = 32'h0000_0000
);
  reg [31:0] dummy;

  task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge i_ref_clk);
      o_hsel <= 1'b1;
      o_haddr <= {24'h00_0000, a};
      o_htrans <= 2'b10;
      o_hwrite <= w;
      do @(posedge i_ref_clk); while (i_hready !== 1'b1);
      o_hsel <= 1'b0;
      o_htrans <= 2'b00;
      o_hwdata <= d;
      do @(posedge i_ref_clk); while (i_hready !== 1'b1);
      q = i_hrdata;
      // released data lines never keep the old word
      o_hwdata <= ~d;
      #1;
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d, dummy);
  endtask

  task rd(input [7:0] a, output [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  // n offset-binary words from base, each one 16'h0101 above the last
  task push(input integer n, input [15:0] base);
    integer    i;
    reg [15:0] s;
    begin
      s = base;
      for (i = 0; i < n; i = i + 1) begin
        wr(`OCS_REG_DATA, {16'h0000, s});
        s = s + 16'h0101;
      end
    end
  endtask
endmodule // ocs_host

// file: verification/tb.sv
`timescale 1ns/1ns
`include "ocs_defines.vh"

module tb;
  reg         i_ref_clk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg         ext_trig  = 1'b0;
  reg         ext_clk   = 1'b0;
  wire        hsel, hwrite, hready, hresp, upd;
  wire [1:0]  htrans;
  wire [2:0]  hsize;
  wire [31:0] haddr, hwdata, hrdata;
  wire [15:0] ao0, ao1, ao2, ao3, dig;
  wire [7:0]  thr;
  integer     err_total = 0;
  integer     n_checks  = 0;
  integer     k;
  reg  [31:0] rd;

  always #5 i_ref_clk = ~i_ref_clk;

  // small store and pacing ceiling keep the run short
  ocs_sequencer #(.DEPTH(64), .PACE_MAX_DIV(64'd1000)) DUT (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_ext_trig(ext_trig), .i_ext_clk(ext_clk), .o_analog_out_0(ao0),
    .o_analog_out_1(ao1), .o_analog_out_2(ao2), .o_analog_out_3(ao3),
    .o_dig_out(dig), .o_thresh_level(thr), .o_update(upd));

  ocs_host host (
    .i_ref_clk(i_ref_clk), .i_hrdata(hrdata), .i_hready(hready), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
    .o_hwdata(hwdata));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task rchk(input [7:0] a, input [31:0] exp);
    begin
      host.rd(a, rd);
      chk(rd, exp);
    end
  endtask

  // bounded wait for the update pulse; exp says whether one is due
  task wup(input [31:0] exp);
    integer i;
    reg     s;
    begin
      s = 1'b0;
      for (i = 0; i < 300 && !s; i = i + 1) begin
        @(posedge i_ref_clk);
        s = (upd === 1'b1);
      end
      chk({31'h0, s}, exp);
    end
  endtask

  // two rising edges on the pacing pin, gap+1 cycles apart
  task epulse(input integer gap);
    begin
      @(posedge i_ref_clk);
      ext_clk <= 1'b1;
      @(posedge i_ref_clk);
      ext_clk <= 1'b0;
      repeat (gap) @(posedge i_ref_clk);
      ext_clk <= 1'b1;
      @(posedge i_ref_clk);
      ext_clk <= 1'b0;
    end
  endtask

  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    chk(32'h0000_0000, 32'h0000_0001);
    summarize;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk(ao0, 32'h0000_8000);
    chk(dig, 32'h0000_0000);
    chk(thr, 32'h0000_0000);
    rchk(`OCS_REG_CHLIST, 32'h0000_0001);
    rchk(`OCS_REG_DIV, 32'h0000_00C8);
    rchk(8'h40, 32'h0000_0000);
    host.wr(`OCS_REG_THRESH, 32'h0000_00FF);
    chk(thr, 32'h0000_00FF);
    host.wr(`OCS_REG_THRESH, 32'h0000_0000);
    chk(thr, 32'h0000_0000);
    $display("test reset_thresh done");

    for (k = 0; k < 5; k = k + 1)
      host.wr(`OCS_REG_SINGLE, {13'h0000, k[2:0], 16'h1111 * k[15:0] + 16'h1111});
    chk(ao0, 32'h0000_1111);
    chk(ao1, 32'h0000_2222);
    chk(ao2, 32'h0000_3333);
    chk(ao3, 32'h0000_4444);
    chk(dig, 32'h0000_5555);
    $display("test single done");

    host.wr(`OCS_REG_CHLIST, 32'h0000_001F);
    host.push(5, 16'hFBFB);
    host.wr(`OCS_REG_CMD, 32'h0000_0001);
    wup(1);
    chk(ao0, 32'h0000_FBFB);
    chk(ao1, 32'h0000_FCFC);
    chk(ao2, 32'h0000_FDFD);
    chk(ao3, 32'h0000_FEFE);
    chk(dig, 32'h0000_FFFF);
    wup(0);
    chk(ao0, 32'h0000_FBFB);
    host.rd(`OCS_REG_STATUS, rd);
    chk(rd[3:2], 32'h0000_0001);
    host.wr(`OCS_REG_CMD, 32'h0000_0006);
    $display("test paced done");

    host.wr(`OCS_REG_CHLIST, 32'h0000_000A);
    host.push(2, 16'h1234);
    host.wr(`OCS_REG_CMD, 32'h0000_0001);
    wup(1);
    chk(ao1, 32'h0000_1234);
    chk(ao3, 32'h0000_1335);
    chk(ao0, 32'h0000_FBFB);
    chk(ao2, 32'h0000_FDFD);
    chk(dig, 32'h0000_FFFF);
    host.wr(`OCS_REG_CMD, 32'h0000_0006);
    $display("test omitted done");

    host.wr(`OCS_REG_CTRL, 32'h0000_0005);
    host.wr(`OCS_REG_CHLIST, 32'h0000_0001);
    host.push(1, 16'h4000);
    host.wr(`OCS_REG_CMD, 32'h0000_0001);
    epulse(4);
    wup(0);
    host.rd(`OCS_REG_STATUS, rd);
    chk(rd[1:0], 32'h0000_0003);
    @(posedge i_ref_clk);
    ext_trig <= 1'b1;
    repeat (8) @(posedge i_ref_clk);
    epulse(1);
    wup(1);
    chk(ao0, 32'h0000_4000);
    host.rd(`OCS_REG_STATUS, rd);
    chk(rd[3], 32'h0000_0001);
    host.wr(`OCS_REG_CMD, 32'h0000_0006);
    $display("test external done");

    host.wr(`OCS_REG_CMD, 32'h0000_0008);
    host.wr(`OCS_REG_CTRL, 32'h0000_000B);
    host.push(2, 16'h2000);
    host.wr(`OCS_REG_CMD, 32'h0000_0001);
    @(posedge i_ref_clk);
    ext_trig <= 1'b0;
    wup(1);
    chk(ao0, 32'h0000_2000);
    wup(1);
    chk(ao0, 32'h0000_2101);
    wup(1);
    chk(ao0, 32'h0000_2000);
    rchk(`OCS_REG_LEVEL, 32'h0000_0002);
    host.wr(`OCS_REG_CMD, 32'h0000_0002);
    $display("test waveform done");
    summarize;
  end
endmodule // tb
